//--- logic/agp_dvo_pkg.sv
// Constants and types shared by the graphics-port pin multiplexer
// ---------------------------------------------------------------
// Functional notes
// - The strap and the AGP parity signal share one pin.
// - The strap level picks AGP mode or digital video mode for the shared pins.
// - An internal pull-down holds the strap low when nothing is fitted.
// - A low strap means a digital video device is attached.
// - Cards pull the strap high; config bit 1 at 74h then reads one.
// - In video mode the eight sideband address pins act as identifier straps.
// - Port B data 0..11 sit on AD3,2,5,4,7,6,8,CBE0,10,9,12,11.
// - Port C data 0..11 sit on AD19..23,CBE3,25,24,27,26,29,28.
// - Port B clock on strobe 0 pair; syncs AD0/AD1; blank CBE1; field AD14.
// - Port C clock on strobe 1 pair; syncs AD17/AD16; blank AD18; field AD31.
// - Serial clock/data pairs and monitor lines use IRDY,DEVSEL,TRDY,FRAME,AD15,STOP.
// - Display interrupt input on AD30; port clock interrupt on AD13.
// - Identifier bit n is taken from sideband address bit n.
// - The power-management signal uses the PIPE pin in video mode.
// ---------------------------------------------------------------
package agp_dvo_pkg;

	// ---------------------------------------------------------------
	// Configuration register
	// ---------------------------------------------------------------
	localparam logic [7:0] STRAP_CFG_OFF = 8'h74;
	localparam int STRAP_CFG_DRIVE_BIT = 0;
	localparam int STRAP_CFG_MODE_BIT = 1;
	localparam logic [31:0] STRAP_CFG_RESET = 32'h00000001;

	// ---------------------------------------------------------------
	// Pin vector: AD[31:0] at 0..31, C/BE#[3:0] at 32..35
	// ---------------------------------------------------------------
	localparam int NPIN = 36;
	localparam int NDATA = 12;
	localparam int NCTL = 5;
	localparam int NSER = 6;
	localparam int PB_MAP [0:11] = '{3, 2, 5, 4, 7, 6, 8, 32, 10, 9, 12, 11};
	localparam int PC_MAP [0:11] = '{19, 20, 21, 22, 23, 35, 25, 24, 27, 26, 29, 28};
	localparam int PB_HSYNC_PIN = 0;
	localparam int PB_VSYNC_PIN = 1;
	localparam int PB_BLANK_PIN = 33;
	localparam int PB_FLDSTL_PIN = 14;
	localparam int PC_HSYNC_PIN = 17;
	localparam int PC_VSYNC_PIN = 16;
	localparam int PC_BLANK_PIN = 18;
	localparam int PC_FLDSTL_PIN = 31;
	localparam int DISP_INT_PIN = 30;
	localparam int CLK_INT_PIN = 13;
	localparam int MON_DATA_PIN = 15;

	// Control pin indices
	localparam int CTL_IRDY = 0;
	localparam int CTL_DEVSEL = 1;
	localparam int CTL_TRDY = 2;
	localparam int CTL_FRAME = 3;
	localparam int CTL_STOP = 4;

	// Serial line indices on the video-side port
	localparam int SER_DISP_CLK = 0;
	localparam int SER_DISP_DATA = 1;
	localparam int SER_SEC_CLK = 2;
	localparam int SER_SEC_DATA = 3;
	localparam int SER_MON_DATA = 4;
	localparam int SER_MON_CLK = 5;

	typedef enum logic [1:0] {
		MODE_DVO = 2'b01,
		MODE_AGP = 2'b10
	} port_mode_t;

endpackage

//--- logic/strap_capture.sv
// Reset-time capture of the mode strap and the identifier straps
`timescale 1ns/1ps
module strap_capture
	import agp_dvo_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic detect_pin,
	input wire logic [7:0] id_pins,
	output port_mode_t mode,
	output logic [7:0] id
);
	port_mode_t mode_q, mode_d;
	logic [7:0] id_q, id_d;

	// Sampled on every edge while reset is low, frozen afterwards
	always_comb begin
		mode_q_hold: begin
			mode_d = mode_q;
			id_d = id_q;
			if (!rst_n) begin
				mode_d = detect_pin ? MODE_AGP : MODE_DVO;
				id_d = id_pins;
			end
		end
	end

	always_ff @(posedge clk) begin
		mode_q <= mode_d;
		id_q <= id_d;
	end

	assign mode = mode_q;
	assign id = id_q;
endmodule

//--- logic/agp_dvo_pin_mux.sv
// Graphics-port pin multiplexer between AGP and two digital video ports
`timescale 1ns/1ps
module agp_dvo_pin_mux
	import agp_dvo_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	// Shared pins
	input wire logic [31:0] gad_in,
	output logic [31:0] gad_out,
	output logic [31:0] gad_oe,
	input wire logic [3:0] gcbe_n_in,
	output logic [3:0] gcbe_n_out,
	output logic [3:0] gcbe_n_oe,
	input wire logic [1:0] gadstb_in,
	output logic [1:0] gadstb_out,
	output logic [1:0] gadstb_oe,
	input wire logic [1:0] gadstb_n_in,
	output logic [1:0] gadstb_n_out,
	output logic [1:0] gadstb_n_oe,
	input wire logic [4:0] gctl_in,
	output logic [4:0] gctl_out,
	output logic [4:0] gctl_oe,
	input wire logic [7:0] gsba_in,
	input wire logic gpipe_n_in,
	input wire logic gpar_in,
	output logic gpar_out,
	output logic gpar_oe,
	output logic strap_pull_down_en,
	// AGP core side
	input wire logic [31:0] agp_ad_out,
	input wire logic [31:0] agp_ad_oe,
	input wire logic [3:0] agp_cbe_n_out,
	input wire logic [3:0] agp_cbe_n_oe,
	input wire logic [1:0] agp_stb_out,
	input wire logic [1:0] agp_stb_n_out,
	input wire logic [1:0] agp_stb_oe,
	input wire logic [4:0] agp_ctl_out,
	input wire logic [4:0] agp_ctl_oe,
	input wire logic agp_par_out,
	input wire logic agp_par_oe,
	output logic [31:0] agp_ad_in,
	output logic [3:0] agp_cbe_n_in,
	output logic [1:0] agp_stb_in,
	output logic [1:0] agp_stb_n_in,
	output logic [4:0] agp_ctl_in,
	output logic [7:0] agp_sba_in,
	output logic agp_pipe_n_in,
	output logic agp_par_in,
	// Digital video core side
	input wire logic [11:0] port_b_pixel_bus,
	input wire logic [11:0] port_c_pixel_bus,
	input wire logic port_b_pixel_clock,
	input wire logic port_b_pixel_clock_n,
	input wire logic port_c_pixel_clock,
	input wire logic port_c_pixel_clock_n,
	input wire logic port_b_line_sync,
	input wire logic port_b_frame_sync,
	input wire logic port_c_line_sync,
	input wire logic port_c_frame_sync,
	input wire logic port_b_blank_border_n,
	input wire logic port_c_blank_border_n,
	output logic port_b_field_stall_in,
	output logic port_c_field_stall_in,
	input wire logic [5:0] serial_out,
	input wire logic [5:0] serial_oe,
	output logic [5:0] serial_in,
	output logic shared_display_interrupt_n,
	output logic shared_port_clock_interrupt,
	output logic display_power_management,
	output logic [7:0] addin_display_identifier,
	output logic agp_mode,
	// Configuration access
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata
);
	// ---------------------------------------------------------------
	// Strap capture
	// ---------------------------------------------------------------
	port_mode_t mode;
	logic [7:0] id;

	// The parity pin is never driven during reset, so it reads the bare strap
	strap_capture strap_capture_i (
		.clk(clk),
		.rst_n(rst_n),
		.detect_pin(gpar_in),
		.id_pins(gsba_in),
		.mode(mode),
		.id(id)
	);

	// Pull-down is always on; a card pulls against it
	assign strap_pull_down_en = 1'b1;

	// ---------------------------------------------------------------
	// Configuration register
	// ---------------------------------------------------------------
	logic drive_en_q, drive_en_d;
	logic [31:0] cfg_rdata_q, cfg_rdata_d;
	logic [31:0] cfg_view;

	always_comb begin
		cfg_view = '0;
		cfg_view[STRAP_CFG_DRIVE_BIT] = drive_en_q;
		cfg_view[STRAP_CFG_MODE_BIT] = (mode == MODE_AGP);
		drive_en_d = drive_en_q;
		cfg_rdata_d = cfg_rdata_q;
		if (!rst_n) begin
			drive_en_d = STRAP_CFG_RESET[STRAP_CFG_DRIVE_BIT];
			cfg_rdata_d = '0;
		end else begin
			if (cfg_wr && cfg_addr == STRAP_CFG_OFF) begin
				drive_en_d = cfg_wdata[STRAP_CFG_DRIVE_BIT];
			end
			if (cfg_rd) begin
				cfg_rdata_d = (cfg_addr == STRAP_CFG_OFF) ? cfg_view : 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk) begin
		drive_en_q <= drive_en_d;
		cfg_rdata_q <= cfg_rdata_d;
	end

	assign cfg_rdata = cfg_rdata_q;

	// ---------------------------------------------------------------
	// Pin-side outputs and enables
	// ---------------------------------------------------------------
	logic [NPIN-1:0] pin_o_q, pin_o_d, pin_e_q, pin_e_d;
	logic [1:0] stb_o_q, stb_o_d, stb_n_o_q, stb_n_o_d, stb_e_q, stb_e_d;
	logic [4:0] ctl_o_q, ctl_o_d, ctl_e_q, ctl_e_d;
	logic par_o_q, par_o_d, par_e_q, par_e_d;

	// Nothing drives during reset: the strap must be read undisturbed
	always_comb begin
		{pin_o_d, pin_e_d, stb_o_d, stb_n_o_d, stb_e_d} = '0;
		{ctl_o_d, ctl_e_d, par_o_d, par_e_d} = '0;
		if (rst_n && mode == MODE_AGP) begin
			pin_o_d = {agp_cbe_n_out, agp_ad_out};
			pin_e_d = {agp_cbe_n_oe, agp_ad_oe};
			{stb_o_d, stb_n_o_d, stb_e_d} = {agp_stb_out, agp_stb_n_out, agp_stb_oe};
			{ctl_o_d, ctl_e_d} = {agp_ctl_out, agp_ctl_oe};
			{par_o_d, par_e_d} = {agp_par_out, agp_par_oe};
		end else if (rst_n) begin
			for (int i = 0; i < NDATA; i++) begin
				pin_o_d[PB_MAP[i]] = port_b_pixel_bus[i];
				pin_e_d[PB_MAP[i]] = drive_en_q;
				pin_o_d[PC_MAP[i]] = port_c_pixel_bus[i];
				pin_e_d[PC_MAP[i]] = drive_en_q;
			end
			pin_o_d[PB_HSYNC_PIN] = port_b_line_sync;
			pin_o_d[PB_VSYNC_PIN] = port_b_frame_sync;
			pin_o_d[PB_BLANK_PIN] = port_b_blank_border_n;
			pin_o_d[PC_HSYNC_PIN] = port_c_line_sync;
			pin_o_d[PC_VSYNC_PIN] = port_c_frame_sync;
			pin_o_d[PC_BLANK_PIN] = port_c_blank_border_n;
			pin_e_d[PB_HSYNC_PIN] = drive_en_q;
			pin_e_d[PB_VSYNC_PIN] = drive_en_q;
			pin_e_d[PB_BLANK_PIN] = drive_en_q;
			pin_e_d[PC_HSYNC_PIN] = drive_en_q;
			pin_e_d[PC_VSYNC_PIN] = drive_en_q;
			pin_e_d[PC_BLANK_PIN] = drive_en_q;
			stb_o_d = {port_c_pixel_clock, port_b_pixel_clock};
			stb_n_o_d = {port_c_pixel_clock_n, port_b_pixel_clock_n};
			stb_e_d = {drive_en_q, drive_en_q};
			// Open-drain serial lines follow the core's own enables
			pin_o_d[MON_DATA_PIN] = serial_out[SER_MON_DATA];
			pin_e_d[MON_DATA_PIN] = serial_oe[SER_MON_DATA];
			ctl_o_d[CTL_IRDY] = serial_out[SER_DISP_CLK];
			ctl_e_d[CTL_IRDY] = serial_oe[SER_DISP_CLK];
			ctl_o_d[CTL_DEVSEL] = serial_out[SER_DISP_DATA];
			ctl_e_d[CTL_DEVSEL] = serial_oe[SER_DISP_DATA];
			ctl_o_d[CTL_TRDY] = serial_out[SER_SEC_CLK];
			ctl_e_d[CTL_TRDY] = serial_oe[SER_SEC_CLK];
			ctl_o_d[CTL_FRAME] = serial_out[SER_SEC_DATA];
			ctl_e_d[CTL_FRAME] = serial_oe[SER_SEC_DATA];
			ctl_o_d[CTL_STOP] = serial_out[SER_MON_CLK];
			ctl_e_d[CTL_STOP] = serial_oe[SER_MON_CLK];
			// Parity pin stays an input: it is the strap in this mode
		end
	end

	always_ff @(posedge clk) begin
		pin_o_q <= pin_o_d;
		pin_e_q <= pin_e_d;
		stb_o_q <= stb_o_d;
		stb_n_o_q <= stb_n_o_d;
		stb_e_q <= stb_e_d;
		ctl_o_q <= ctl_o_d;
		ctl_e_q <= ctl_e_d;
		par_o_q <= par_o_d;
		par_e_q <= par_e_d;
	end

	assign gad_out = pin_o_q[31:0];
	assign gad_oe = pin_e_q[31:0];
	assign gcbe_n_out = pin_o_q[35:32];
	assign gcbe_n_oe = pin_e_q[35:32];
	assign gadstb_out = stb_o_q;
	assign gadstb_n_out = stb_n_o_q;
	assign gadstb_oe = stb_e_q;
	assign gadstb_n_oe = stb_e_q;
	assign gctl_out = ctl_o_q;
	assign gctl_oe = ctl_e_q;
	assign gpar_out = par_o_q;
	assign gpar_oe = par_e_q;

	// ---------------------------------------------------------------
	// Core-side inputs
	// ---------------------------------------------------------------
	logic [54:0] agp_in_q, agp_in_d;
	logic [5:0] ser_in_q, ser_in_d;
	logic [12:0] dvo_in_q, dvo_in_d;

	// The inactive side sees idle levels, so it never acts on the other's traffic
	always_comb begin
		agp_in_d = {1'b1, 1'b0, 8'h00, 5'h1f, 2'h0, 2'h0, 4'hf, 32'h00000000};
		ser_in_d = 6'h3f;
		dvo_in_d = {8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
		if (rst_n && mode == MODE_AGP) begin
			agp_in_d = {gpipe_n_in, gpar_in, gsba_in, gctl_in, gadstb_n_in, gadstb_in,
				gcbe_n_in, gad_in};
		end else if (rst_n) begin
			ser_in_d = {gctl_in[CTL_STOP], gad_in[MON_DATA_PIN], gctl_in[CTL_FRAME],
				gctl_in[CTL_TRDY], gctl_in[CTL_DEVSEL], gctl_in[CTL_IRDY]};
			dvo_in_d = {id,
				gpipe_n_in,
				gad_in[CLK_INT_PIN],
				gad_in[DISP_INT_PIN],
				gad_in[PC_FLDSTL_PIN],
				gad_in[PB_FLDSTL_PIN]};
		end
	end

	always_ff @(posedge clk) begin
		agp_in_q <= agp_in_d;
		ser_in_q <= ser_in_d;
		dvo_in_q <= dvo_in_d;
	end

	assign agp_ad_in = agp_in_q[31:0];
	assign agp_cbe_n_in = agp_in_q[35:32];
	assign agp_stb_in = agp_in_q[37:36];
	assign agp_stb_n_in = agp_in_q[39:38];
	assign agp_ctl_in = agp_in_q[44:40];
	assign agp_sba_in = agp_in_q[52:45];
	assign agp_par_in = agp_in_q[53];
	assign agp_pipe_n_in = agp_in_q[54];
	assign serial_in = ser_in_q;
	assign port_b_field_stall_in = dvo_in_q[0];
	assign port_c_field_stall_in = dvo_in_q[1];
	assign shared_display_interrupt_n = dvo_in_q[2];
	assign shared_port_clock_interrupt = dvo_in_q[3];
	assign display_power_management = dvo_in_q[4];
	assign addin_display_identifier = dvo_in_q[12:5];
	assign agp_mode = (mode == MODE_AGP);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	sequence s_cfg_read;
		cfg_rd && cfg_addr == STRAP_CFG_OFF;
	endsequence

	sequence s_video_run;
		rst_n && !agp_mode && drive_en_q;
	endsequence

	property p_mode_hold;
		@(posedge clk) disable iff (!rst_n) $stable(agp_mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

	property p_cfg_mode;
		@(posedge clk) disable iff (!rst_n) s_cfg_read |=> cfg_rdata[STRAP_CFG_MODE_BIT] == agp_mode;
	endproperty
	a_cfg_mode: assert property (p_cfg_mode) else $error("mode bit wrong");

	property p_par_quiet;
		@(posedge clk) disable iff (!rst_n) !agp_mode |=> !gpar_oe;
	endproperty
	a_par_quiet: assert property (p_par_quiet) else $error("strap pin driven");

	property p_port_b_map;
		@(posedge clk) disable iff (!rst_n) s_video_run |=>
			gad_out[3] == $past(port_b_pixel_bus[0]) &&
			gcbe_n_out[0] == $past(port_b_pixel_bus[7]) && gad_oe[11];
	endproperty
	a_port_b_map: assert property (p_port_b_map) else $error("port B map");

	property p_port_c_map;
		@(posedge clk) disable iff (!rst_n) s_video_run |=>
			gcbe_n_out[3] == $past(port_c_pixel_bus[5]) &&
			gad_out[28] == $past(port_c_pixel_bus[11]);
	endproperty
	a_port_c_map: assert property (p_port_c_map) else $error("port C map");

	property p_clock_pair;
		@(posedge clk) disable iff (!rst_n) s_video_run |=>
			gadstb_out[0] == $past(port_b_pixel_clock) &&
			gadstb_n_out[1] == $past(port_c_pixel_clock_n);
	endproperty
	a_clock_pair: assert property (p_clock_pair) else $error("clock pair map");

	property p_serial_map;
		@(posedge clk) disable iff (!rst_n) !agp_mode ##1 !agp_mode |->
			gctl_oe[0] == $past(serial_oe[0]) && gad_oe[15] == $past(serial_oe[4]);
	endproperty
	a_serial_map: assert property (p_serial_map) else $error("serial map");

	property p_interrupt;
		@(posedge clk) disable iff (!rst_n) !agp_mode |=>
			shared_display_interrupt_n == $past(gad_in[30]) &&
			display_power_management == $past(gpipe_n_in);
	endproperty
	a_interrupt: assert property (p_interrupt) else $error("input pin map");

	property p_agp_pass;
		@(posedge clk) disable iff (!rst_n) agp_mode |=>
			gad_oe == $past(agp_ad_oe) && serial_in == 6'h3f;
	endproperty
	a_agp_pass: assert property (p_agp_pass) else $error("wrong owner drives");
endmodule

//--- dv/far_side_model.sv
// Far-side model: add-in card or on-board encoders plus board straps
`timescale 1ns/1ps
module far_side_model (
	input wire logic card_fitted,
	input wire logic [7:0] id_strap,
	input wire logic [31:0] ext_ad,
	input wire logic [3:0] ext_cbe,
	input wire logic [4:0] ext_ctl,
	input wire logic ext_pipe,
	input wire logic [31:0] gad_out,
	input wire logic [31:0] gad_oe,
	input wire logic [3:0] gcbe_n_out,
	input wire logic [3:0] gcbe_n_oe,
	input wire logic [1:0] gadstb_out,
	input wire logic [1:0] gadstb_oe,
	input wire logic [1:0] gadstb_n_out,
	input wire logic [1:0] gadstb_n_oe,
	input wire logic [4:0] gctl_out,
	input wire logic [4:0] gctl_oe,
	input wire logic gpar_out,
	input wire logic gpar_oe,
	output logic [31:0] gad_in,
	output logic [3:0] gcbe_n_in,
	output logic [1:0] gadstb_in,
	output logic [1:0] gadstb_n_in,
	output logic [4:0] gctl_in,
	output logic [7:0] gsba_in,
	output logic gpipe_n_in,
	output logic gpar_in
);
	// A pin the device drives shows its value; otherwise the far side's level
	assign gad_in = (gad_oe & gad_out) | (~gad_oe & ext_ad);
	assign gcbe_n_in = (gcbe_n_oe & gcbe_n_out) | (~gcbe_n_oe & ext_cbe);
	assign gadstb_in = (gadstb_oe & gadstb_out) | (~gadstb_oe & ext_cbe[1:0]);
	assign gadstb_n_in = (gadstb_n_oe & gadstb_n_out) | (~gadstb_n_oe & ~ext_cbe[1:0]);
	assign gctl_in = (gctl_oe & gctl_out) | (~gctl_oe & ext_ctl);
	// A card pulls the shared parity pin high; with nothing fitted the pull-down wins
	assign gpar_in = gpar_oe ? gpar_out : card_fitted;
	assign gsba_in = id_strap;
	assign gpipe_n_in = ext_pipe;
endmodule

//--- dv/agp_dvo_pin_mux_tb_top.sv
// Self-checking bench for the graphics-port pin multiplexer
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module agp_dvo_pin_mux_tb_top;
	import agp_dvo_pkg::*;
	logic clk, rst_n, card_fitted, ext_pipe, gpipe_n_in, gpar_in, gpar_out, gpar_oe;
	logic strap_pull_down_en, agp_par_out, agp_par_oe, agp_pipe_n_in, agp_par_in;
	logic port_b_pixel_clock, port_b_pixel_clock_n, port_c_pixel_clock, port_c_pixel_clock_n;
	logic port_b_line_sync, port_b_frame_sync, port_c_line_sync, port_c_frame_sync;
	logic port_b_blank_border_n, port_c_blank_border_n, port_b_field_stall_in;
	logic port_c_field_stall_in, shared_display_interrupt_n, shared_port_clock_interrupt;
	logic display_power_management, agp_mode, cfg_wr, cfg_rd;
	logic [31:0] gad_in, gad_out, gad_oe, agp_ad_out, agp_ad_oe, agp_ad_in;
	logic [31:0] cfg_wdata, cfg_rdata, ext_ad;
	logic [3:0] gcbe_n_in, gcbe_n_out, gcbe_n_oe, agp_cbe_n_out, agp_cbe_n_oe, agp_cbe_n_in;
	logic [3:0] ext_cbe;
	logic [1:0] gadstb_in, gadstb_out, gadstb_oe, gadstb_n_in, gadstb_n_out, gadstb_n_oe;
	logic [1:0] agp_stb_out, agp_stb_n_out, agp_stb_oe, agp_stb_in, agp_stb_n_in;
	logic [4:0] gctl_in, gctl_out, gctl_oe, agp_ctl_out, agp_ctl_oe, agp_ctl_in, ext_ctl;
	logic [7:0] gsba_in, agp_sba_in, addin_display_identifier, cfg_addr, id_strap;
	logic [11:0] port_b_pixel_bus, port_c_pixel_bus;
	logic [5:0] serial_out, serial_oe, serial_in;
	logic [35:0] po, poe;
	int err_total, check_count;
	// Pin index per data bit: AD pins 0..31, C/BE# pins 32..35
	int pb_pin [12] = '{3, 2, 5, 4, 7, 6, 8, 32, 10, 9, 12, 11};
	int pc_pin [12] = '{19, 20, 21, 22, 23, 35, 25, 24, 27, 26, 29, 28};
	assign po = {gcbe_n_out, gad_out};
	assign poe = {gcbe_n_oe, gad_oe};

	agp_dvo_pin_mux agp_dvo_pin_mux_i (.*);
	far_side_model far_side_model_i (.*);

	always #2.5 clk = ~clk;

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task cyc();
		@(negedge clk);
	endtask
	task do_reset(input logic card, input logic [7:0] id);
		card_fitted = card;
		id_strap = id;
		rst_n = 1'b0;
		repeat (10) cyc();
		rst_n = 1'b1;
		repeat (2) cyc();
	endtask
	task cfg_write(input logic [7:0] a, input logic [31:0] d);
		{cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
		cyc();
		cfg_wr = 1'b0;
		cyc();
	endtask
	task cfg_check(input logic [7:0] a, input logic [31:0] e);
		{cfg_rd, cfg_addr} = {1'b1, a};
		cyc();
		cfg_rd = 1'b0;
		`CHK(cfg_rdata, e)
		cyc();
	endtask
	task test_done();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task video_strap_case();
		do_reset(1'b0, 8'ha5);
		id_strap = 8'h5a;
		cyc();
		`CHK(agp_mode, 1'b0)
		`CHK(strap_pull_down_en, 1'b1)
		`CHK(addin_display_identifier, 8'ha5)
		`CHK(gpar_oe, 1'b0)
		cfg_check(8'h74, 32'h00000001);
		cfg_check(8'h70, 32'h00000000);
	endtask
	task pixel_case();
		for (int i = 0; i < 12; i++) begin
			port_b_pixel_bus = 12'h001 << i;
			port_c_pixel_bus = ~(12'h001 << i);
			cyc();
			`CHK({po[pb_pin[i]], poe[pb_pin[i]]}, 2'b11)
			`CHK({po[pc_pin[i]], poe[pc_pin[i]]}, 2'b01)
		end
	endtask
	task sync_case(input logic v);
		{port_b_line_sync, port_b_frame_sync, port_b_blank_border_n} = {v, ~v, v};
		{port_b_pixel_clock, port_b_pixel_clock_n} = {~v, v};
		{port_c_line_sync, port_c_frame_sync, port_c_blank_border_n} = {~v, v, ~v};
		{port_c_pixel_clock, port_c_pixel_clock_n} = {v, ~v};
		cyc();
		`CHK({gad_out[1:0], gcbe_n_out[1], gadstb_out[0], gadstb_n_out[0]}, {~v, v, v, ~v, v})
		`CHK({gad_oe[1:0], gcbe_n_oe[1], gadstb_oe[0], gadstb_n_oe[0]}, 5'h1f)
		`CHK({gad_out[18:16], gadstb_out[1], gadstb_n_out[1]}, {~v, ~v, v, v, ~v})
	endtask
	task input_case(input logic v);
		{ext_ad[31:30], ext_ad[15:13]} = {~v, v, v, v, ~v};
		ext_ctl = v ? 5'h0b : 5'h14;
		ext_pipe = v;
		serial_oe = 6'h00;
		// Enables drop one edge later; the freed lines are sampled the edge after
		repeat (2) cyc();
		`CHK({port_b_field_stall_in, port_c_field_stall_in}, {v, ~v})
		`CHK({shared_display_interrupt_n, shared_port_clock_interrupt}, {v, ~v})
		`CHK(display_power_management, v)
		`CHK(serial_in, {ext_ctl[4], v, ext_ctl[3:0]})
		`CHK(agp_ctl_in, 5'h1f)
		{serial_out, serial_oe} = {6'h00, 6'h3f};
		cyc();
		`CHK({gctl_oe, gad_oe[15], gctl_out, gad_out[15]}, 12'hfc0)
	endtask
	task drive_enable_case();
		port_b_pixel_bus = 12'h001;
		cfg_write(8'h74, 32'hfffffffe);
		cfg_check(8'h74, 32'h00000000);
		`CHK(gad_oe[3], 1'b0)
		cfg_write(8'h30, 32'hffffffff);
		cfg_check(8'h74, 32'h00000000);
		cfg_write(8'h74, 32'h00000001);
		`CHK(gad_oe[3], 1'b1)
	endtask
	task agp_case();
		do_reset(1'b1, 8'h3c);
		`CHK({agp_mode, addin_display_identifier}, 9'h100)
		cfg_check(8'h74, 32'h00000003);
		{agp_ad_out, agp_ad_oe} = {32'h12345678, 32'hffffffff};
		{agp_cbe_n_out, agp_cbe_n_oe, agp_ctl_out, agp_ctl_oe} = {4'h5, 4'hf, 5'h0a, 5'h1f};
		{agp_stb_out, agp_stb_n_out, agp_stb_oe} = {2'b01, 2'b10, 2'b11};
		{agp_par_out, agp_par_oe} = 2'b01;
		port_b_pixel_bus = 12'hfff;
		cyc();
		`CHK({gad_out, gad_oe}, {32'h12345678, 32'hffffffff})
		`CHK({gcbe_n_out, gctl_out, gadstb_out, gadstb_n_out}, {4'h5, 5'h0a, 4'h6})
		`CHK({gpar_out, gpar_oe}, 2'b01)
		{agp_ad_oe, agp_par_oe, ext_ad, ext_cbe, ext_ctl} = {33'h0, 32'hcafef00d, 4'h9, 5'h13};
		{agp_cbe_n_oe, agp_ctl_oe, ext_pipe} = 10'h0;
		card_fitted = 1'b0;
		// Own drive holds the pins for one more edge before the far side shows
		repeat (2) cyc();
		`CHK({gad_oe, gpar_oe}, 33'h0)
		`CHK({agp_stb_in, agp_stb_n_in}, 4'h6)
		`CHK({agp_ad_in, agp_cbe_n_in, agp_ctl_in}, {32'hcafef00d, 4'h9, 5'h13})
		`CHK({agp_par_in, agp_pipe_n_in, agp_sba_in}, {2'b00, 8'h3c})
		`CHK(agp_mode, 1'b1)
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{clk, rst_n, card_fitted, id_strap, ext_pipe, err_total, check_count} = '0;
		{cfg_wr, cfg_rd, cfg_addr, cfg_wdata, agp_ad_out, agp_ad_oe, agp_par_out} = '0;
		{agp_cbe_n_out, agp_cbe_n_oe, agp_stb_out, agp_stb_n_out, agp_stb_oe} = '0;
		{agp_ctl_out, agp_ctl_oe, agp_par_oe, port_b_pixel_bus, port_c_pixel_bus} = '0;
		{serial_out, serial_oe, ext_ad, ext_cbe, ext_ctl} = '0;
		{port_b_line_sync, port_b_frame_sync, port_b_blank_border_n} = '0;
		{port_b_pixel_clock, port_b_pixel_clock_n, port_c_pixel_clock} = '0;
		{port_c_pixel_clock_n, port_c_line_sync, port_c_frame_sync} = '0;
		port_c_blank_border_n = 1'b0;
		video_strap_case();
		pixel_case();
		sync_case(1'b1);
		sync_case(1'b0);
		input_case(1'b1);
		input_case(1'b0);
		drive_enable_case();
		agp_case();
		test_done();
	end

	// Cuts a hung run short
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		test_done();
	end
endmodule
